// [rtl/rch_pkg.sv]
// Shared constants and types for the remote-control handshake.
// Assumes one 50 MHz clock on both ends.
package rch_pkg;
  // ----------------------------------------------------------------
  // Clock and millisecond tick
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MS_HZ = 1000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / MS_HZ;
  localparam int unsigned MS_W = 14;
  // ----------------------------------------------------------------
  // Times in ms
  // ----------------------------------------------------------------
  localparam int unsigned T_STROBE_MS = 50;
  localparam int unsigned T_ATTACH_MS = 1;
  localparam int unsigned T_BUSY_STD_MS = 50;
  localparam int unsigned T_BUSY_SLOT_MS = 100;
  localparam int unsigned T_BUSY_AREA_MS = 8000;
  localparam int unsigned T_BUSY_SAME_MS = 50;
  localparam int unsigned T_ACK_STD_MS = 1;
  localparam int unsigned T_ACK_SLOT_MS = 5;
  localparam int unsigned T_RES_MS = 50;
  localparam int unsigned T_READY_MS = 1;
  localparam int unsigned T_SLOT_CMD_MS = 1;
  localparam int unsigned T_SLOT_GAP_MS = 10;
  localparam int unsigned T_ADV_CMD_MS = 1;
  localparam int unsigned T_ADV_GAP_MS = 1;
  // ----------------------------------------------------------------
  // Strobe vector layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned N_STROBE = 9;
  localparam int unsigned IDX_VERIFY = 0;
  localparam int unsigned IDX_START = 1;
  localparam int unsigned IDX_CONFIRM = 2;
  localparam int unsigned IDX_ABORT = 3;
  localparam int unsigned IDX_ADVANCE = 4;
  localparam int unsigned IDX_ACK = 5;
  localparam int unsigned IDX_SLOT0 = 6;
  localparam int unsigned SLOT_W = 3;
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic [SLOT_W-1:0] SLOT_RST = 3'h0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STD = 2'b00,
    MODE_SLOT = 2'b01,
    MODE_SIMPLE = 2'b10
  } rch_mode_t;
  typedef enum logic [2:0] {
    CMD_VERIFY = 3'b000,
    CMD_START = 3'b001,
    CMD_CONFIRM = 3'b010,
    CMD_ABORT = 3'b011,
    CMD_ADVANCE = 3'b100,
    CMD_SLOT = 3'b101
  } rch_cmd_t;
endpackage

// [rtl/rch_if.sv]
// Remote-control pins between programmer and controller.
// All strobes and result lines are active low; testbench joins ends.
interface rch_if;
  logic host_attached;
  logic busy;
  logic result_ok_n;
  logic result_fail_n;
  logic verify_cmd_n;
  logic start_n;
  logic confirm_key_n;
  logic abort_n;
  logic advance_program_n;
  logic result_ack_n;
  logic slot_select_bit_zero_n;
  logic slot_select_bit_one_n;
  logic slot_select_bit_two_n;
  modport dev (
    output host_attached, busy, result_ok_n, result_fail_n,
    input verify_cmd_n, start_n, confirm_key_n, abort_n,
    input advance_program_n, result_ack_n,
    input slot_select_bit_zero_n, slot_select_bit_one_n,
    input slot_select_bit_two_n
  );
  modport host (
    input host_attached, busy, result_ok_n, result_fail_n,
    output verify_cmd_n, start_n, confirm_key_n, abort_n,
    output advance_program_n, result_ack_n,
    output slot_select_bit_zero_n, slot_select_bit_one_n,
    output slot_select_bit_two_n
  );
endinterface

// [rtl/rch_device.sv]
// Programmer end of the remote-control handshake.
// Assumes strobes synchronous to mclk; the job itself runs outside.

// Functional notes
// [R1] Controller holds strobes low at least 50 ms
// [R2] Controller waits 1 ms after attach
// [R3] Busy within 50/100 ms of command
// [R4] Simple: busy 8000 ms area change, else 50
// [R5] Ack only after busy low 1/5 ms
// [R6] Result line low within 50 ms of ack
// [R7] Standard: ready 1 ms after busy falls
// [R8] Slot select 1 ms before command
// [R9] Slot select 10 ms after busy falls
// [R10] Advance 1 ms before command
// [R11] Advance 1 ms after busy falls
// [R12] Active-low, filtered inputs; busy spans operation
module rch_device #(
  parameter int unsigned TICK_CYC = rch_pkg::CLK_PER_MS,
  parameter int unsigned GLITCH_CYC = 16,
  parameter int unsigned AREA_MS = 20
) (
  input wire logic mclk,
  input wire logic rst_n,
  rch_if.dev link,
  input wire rch_pkg::rch_mode_t mode,
  input wire logic attach_req,
  input wire logic op_done,
  input wire logic op_pass,
  output logic op_start,
  output rch_pkg::rch_cmd_t op_code,
  output logic op_abort,
  output logic area_advance,
  output logic [rch_pkg::SLOT_W-1:0] slot_num
);
  localparam int unsigned N = rch_pkg::N_STROBE;
  localparam int unsigned MW = rch_pkg::MS_W;
  localparam int unsigned TW = $clog2(TICK_CYC);
  localparam int unsigned GW = $clog2(GLITCH_CYC + 1);
  localparam int unsigned S0 = rch_pkg::IDX_SLOT0;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_DELAY = 2'b01,
    D_RUN = 2'b10
  } rch_dstate_t;

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_cnt_reg;
  logic tick;
  assign tick = (tick_cnt_reg == TW'(TICK_CYC - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Strobe filters
  // ----------------------------------------------------------------
  logic [N-1:0] raw_n;
  logic [N-1:0] low_w;
  logic [N-1:0] low_dly_reg;
  logic [N-1:0] fall;
  assign raw_n = {link.slot_select_bit_two_n,
                  link.slot_select_bit_one_n,
                  link.slot_select_bit_zero_n,
                  link.result_ack_n, link.advance_program_n,
                  link.abort_n, link.confirm_key_n,
                  link.start_n, link.verify_cmd_n};

  // A strobe counts once it stays low GLITCH_CYC + 1 cycles in a row
  genvar gi;
  for (gi = 0; gi < N; gi++) begin : g_flt
    logic samp_reg;
    logic low_reg;
    logic [GW-1:0] cnt_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        samp_reg <= rch_pkg::STROBE_IDLE;
        low_reg <= 1'b0;
        cnt_reg <= '0;
      end else begin
        samp_reg <= raw_n[gi];
        if (samp_reg) begin // [R12]
          cnt_reg <= '0;
          low_reg <= 1'b0;
        end else if (cnt_reg == GW'(GLITCH_CYC)) begin
          low_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
    assign low_w[gi] = low_reg;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_dly_reg <= '0;
    end else begin
      low_dly_reg <= low_w;
    end
  end
  assign fall = low_w & ~low_dly_reg;

  // ----------------------------------------------------------------
  // Attach indication and settle guard
  // ----------------------------------------------------------------
  logic attached_reg;
  logic [MW-1:0] att_cnt_reg;
  logic att_ok;
  assign att_ok = (att_cnt_reg >= MW'(rch_pkg::T_ATTACH_MS));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      attached_reg <= 1'b0;
      att_cnt_reg <= '0;
    end else begin
      attached_reg <= attach_req;
      if (!attached_reg) begin
        att_cnt_reg <= '0;
      end else if (tick && !att_ok) begin // [R2]
        att_cnt_reg <= att_cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  rch_dstate_t state_reg;
  logic busy_reg;
  logic area_chg_reg;
  logic [MW-1:0] dly_cnt_reg;
  logic cmd_hit;
  logic accept;
  logic end_evt;
  logic end_pass;
  logic do_abort;
  rch_pkg::rch_cmd_t cmd_sel;

  // Idle state means ready at once after busy falls
  assign cmd_hit = fall[rch_pkg::IDX_VERIFY] |
                   fall[rch_pkg::IDX_START] |
                   fall[rch_pkg::IDX_CONFIRM];
  assign accept = (state_reg == D_IDLE) && att_ok && cmd_hit; // [R7]
  assign do_abort = fall[rch_pkg::IDX_ABORT] && att_ok &&
                    (state_reg != D_IDLE);
  assign end_evt = ((state_reg == D_RUN) && op_done) || do_abort;
  assign end_pass = op_pass && !do_abort;

  always_comb begin
    if (fall[rch_pkg::IDX_VERIFY]) begin
      cmd_sel = rch_pkg::CMD_VERIFY;
    end else if (fall[rch_pkg::IDX_START]) begin
      cmd_sel = rch_pkg::CMD_START;
    end else begin
      cmd_sel = rch_pkg::CMD_CONFIRM;
    end
  end

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  // Busy rises the cycle after accept, or AREA_MS later after an area change in simple mode, well inside 50 and 100 ms
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= D_IDLE;
      busy_reg <= 1'b0;
      dly_cnt_reg <= '0;
      op_start <= 1'b0;
      op_abort <= 1'b0;
      op_code <= rch_pkg::CMD_VERIFY;
    end else begin
      op_start <= 1'b0;
      op_abort <= do_abort;
      case (state_reg)
        D_IDLE: begin
          if (accept) begin
            op_code <= cmd_sel;
            dly_cnt_reg <= '0;
            if (mode == rch_pkg::MODE_SIMPLE && area_chg_reg) begin
              state_reg <= D_DELAY; // [R4]
            end else begin
              state_reg <= D_RUN; // [R3]
              busy_reg <= 1'b1;
              op_start <= 1'b1;
            end
          end
        end
        D_DELAY: begin
          if (do_abort) begin
            state_reg <= D_IDLE;
          end else if (dly_cnt_reg >= MW'(AREA_MS)) begin
            state_reg <= D_RUN; // [R4]
            busy_reg <= 1'b1;
            op_start <= 1'b1;
          end else if (tick) begin
            dly_cnt_reg <= dly_cnt_reg + 1'b1;
          end
        end
        D_RUN: begin
          if (end_evt) begin // [R12]
            state_reg <= D_IDLE;
            busy_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= D_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result lines
  // ----------------------------------------------------------------
  logic res_valid_reg;
  logic res_pass_reg;
  logic ok_n_reg;
  logic fail_n_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid_reg <= 1'b0;
      res_pass_reg <= 1'b0;
      ok_n_reg <= 1'b1;
      fail_n_reg <= 1'b1;
    end else begin
      if (accept) begin
        res_valid_reg <= 1'b0;
        ok_n_reg <= 1'b1;
        fail_n_reg <= 1'b1;
      end else if (end_evt) begin
        res_valid_reg <= 1'b1;
        res_pass_reg <= end_pass;
      end
      // Ack is answered on the next edge, far below 50 ms
      if (fall[rch_pkg::IDX_ACK] && res_valid_reg && !accept) begin
        ok_n_reg <= ~res_pass_reg; // [R6]
        fail_n_reg <= res_pass_reg; // [R6]
      end
    end
  end

  // ----------------------------------------------------------------
  // Slot select and program area
  // ----------------------------------------------------------------
  logic [rch_pkg::SLOT_W-1:0] slot_reg;
  logic slot_fall;
  logic adv_hit;
  assign slot_fall = |fall[S0 +: rch_pkg::SLOT_W];
  assign adv_hit = fall[rch_pkg::IDX_ADVANCE] && att_ok &&
                   (mode == rch_pkg::MODE_SIMPLE) &&
                   (state_reg == D_IDLE);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slot_reg <= rch_pkg::SLOT_RST;
    end else if (slot_fall && att_ok &&
                 mode == rch_pkg::MODE_SLOT) begin
      slot_reg <= low_w[S0 +: rch_pkg::SLOT_W];
    end
  end

  // A new advance in the same cycle as accept is kept
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      area_chg_reg <= 1'b0;
      area_advance <= 1'b0;
    end else begin
      area_advance <= adv_hit;
      if (adv_hit) begin
        area_chg_reg <= 1'b1;
      end else if (accept) begin
        area_chg_reg <= 1'b0;
      end
    end
  end

  assign link.host_attached = attached_reg;
  assign link.busy = busy_reg;
  assign link.result_ok_n = ok_n_reg;
  assign link.result_fail_n = fail_n_reg;
  assign slot_num = slot_reg;
endmodule // rch_device

// [rtl/rch_host.sv]
// Controller end of the remote-control handshake.
// Assumes device pins synchronous to mclk; one request at a time.
module rch_host #(
  parameter int unsigned TICK_CYC = rch_pkg::CLK_PER_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  rch_if.host link,
  input wire rch_pkg::rch_mode_t mode,
  input wire logic cmd_valid,
  input wire rch_pkg::rch_cmd_t cmd_code,
  input wire logic [rch_pkg::SLOT_W-1:0] cmd_slot,
  output logic cmd_ready,
  output logic res_valid,
  output logic res_pass,
  output logic res_timeout
);
  localparam int unsigned N = rch_pkg::N_STROBE;
  localparam int unsigned MW = rch_pkg::MS_W;
  localparam int unsigned TW = $clog2(TICK_CYC);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_GAP = 3'b001, H_DRIVE = 3'b010,
    H_WBUSY = 3'b011, H_WIDLE = 3'b100, H_ACKGAP = 3'b101,
    H_ACK = 3'b110, H_WRES = 3'b111
  } rch_hstate_t;

  // ----------------------------------------------------------------
  // Tick and elapsed-time counters
  // ----------------------------------------------------------------
  // Tick phase is free, so every wait counts one extra ms
  logic [TW-1:0] tick_cnt_reg;
  logic tick;
  logic busy_dly_reg;
  logic [MW-1:0] since_att_reg, since_fall_reg, since_pre_reg;
  logic pre_end;
  assign tick = (tick_cnt_reg == TW'(TICK_CYC - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_dly_reg <= 1'b0;
      since_att_reg <= '0;
      since_fall_reg <= '0;
      since_pre_reg <= '0;
    end else begin
      busy_dly_reg <= link.busy;
      if (!link.host_attached) begin
        since_att_reg <= '0;
      end else if (tick && !(&since_att_reg)) begin
        since_att_reg <= since_att_reg + 1'b1;
      end
      if (busy_dly_reg && !link.busy) begin
        since_fall_reg <= '0;
      end else if (tick && !(&since_fall_reg)) begin
        since_fall_reg <= since_fall_reg + 1'b1;
      end
      if (pre_end) begin
        since_pre_reg <= '0;
      end else if (tick && !(&since_pre_reg)) begin
        since_pre_reg <= since_pre_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  rch_hstate_t state_reg;
  rch_pkg::rch_cmd_t code_reg;
  logic [N-1:0] strobe_reg;
  logic [MW-1:0] cnt_reg;
  logic op_cmd, gap_ok, wide;
  logic [MW-1:0] gap_ms, ack_ms, busy_ms;

  assign op_cmd = (code_reg == rch_pkg::CMD_VERIFY) ||
                  (code_reg == rch_pkg::CMD_START) ||
                  (code_reg == rch_pkg::CMD_CONFIRM);
  assign wide = (cnt_reg > MW'(rch_pkg::T_STROBE_MS)); // [R1]
  assign pre_end = (state_reg == H_DRIVE) && wide && !op_cmd;
  assign cmd_ready = (state_reg == H_IDLE) && link.host_attached;
  assign ack_ms = (mode == rch_pkg::MODE_SLOT) ?
                  MW'(rch_pkg::T_ACK_SLOT_MS) :
                  MW'(rch_pkg::T_ACK_STD_MS); // [R5]
  assign busy_ms = (mode == rch_pkg::MODE_SIMPLE) ?
                   MW'(rch_pkg::T_BUSY_AREA_MS) :
                   MW'(rch_pkg::T_BUSY_SLOT_MS);

  always_comb begin
    gap_ms = '0;
    gap_ok = (since_att_reg > MW'(rch_pkg::T_ATTACH_MS)) && // [R2]
             !link.busy;
    case (code_reg)
      rch_pkg::CMD_SLOT: gap_ms = MW'(rch_pkg::T_SLOT_GAP_MS); // [R9]
      rch_pkg::CMD_ADVANCE: gap_ms = MW'(rch_pkg::T_ADV_GAP_MS); // [R11]
      default: gap_ms = '0;
    endcase
    if (gap_ms != '0 && since_fall_reg <= gap_ms) begin
      gap_ok = 1'b0;
    end
    if (op_cmd && mode != rch_pkg::MODE_STD &&
        since_pre_reg <= MW'(rch_pkg::T_SLOT_CMD_MS)) begin
      gap_ok = 1'b0; // [R8] [R10]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= H_IDLE;
      code_reg <= rch_pkg::CMD_VERIFY;
      strobe_reg <= '0;
      cnt_reg <= '0;
      res_valid <= 1'b0;
      res_pass <= 1'b0;
      res_timeout <= 1'b0;
    end else begin
      res_valid <= 1'b0;
      res_timeout <= 1'b0;
      if (tick && !(&cnt_reg)) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      case (state_reg)
        H_IDLE: if (cmd_valid && cmd_ready) begin
          code_reg <= cmd_code;
          state_reg <= H_GAP;
        end
        H_GAP: if (gap_ok) begin
          cnt_reg <= '0;
          state_reg <= H_DRIVE;
          case (code_reg)
            rch_pkg::CMD_VERIFY: strobe_reg[rch_pkg::IDX_VERIFY] <= 1'b1;
            rch_pkg::CMD_START: strobe_reg[rch_pkg::IDX_START] <= 1'b1;
            rch_pkg::CMD_CONFIRM: strobe_reg[rch_pkg::IDX_CONFIRM] <= 1'b1;
            rch_pkg::CMD_ABORT: strobe_reg[rch_pkg::IDX_ABORT] <= 1'b1;
            rch_pkg::CMD_ADVANCE: strobe_reg[rch_pkg::IDX_ADVANCE] <= 1'b1;
            default: strobe_reg[rch_pkg::IDX_SLOT0 +: rch_pkg::SLOT_W]
                       <= cmd_slot;
          endcase
        end
        H_DRIVE: if (wide) begin
          strobe_reg <= '0;
          cnt_reg <= '0;
          state_reg <= op_cmd ? H_WBUSY : H_IDLE;
        end
        H_WBUSY: if (link.busy) begin
          state_reg <= H_WIDLE;
        end else if (cnt_reg > busy_ms) begin
          res_timeout <= 1'b1;
          state_reg <= H_IDLE;
        end
        H_WIDLE: if (!link.busy) begin
          state_reg <= H_ACKGAP;
        end
        H_ACKGAP: if (since_fall_reg > ack_ms) begin // [R5]
          strobe_reg[rch_pkg::IDX_ACK] <= 1'b1;
          cnt_reg <= '0;
          state_reg <= H_ACK;
        end
        H_ACK: if (wide) begin
          strobe_reg <= '0;
          cnt_reg <= '0;
          state_reg <= H_WRES;
        end
        H_WRES: if (!link.result_ok_n || !link.result_fail_n) begin
          res_valid <= 1'b1;
          res_pass <= !link.result_ok_n;
          state_reg <= H_IDLE;
        end else if (cnt_reg > MW'(rch_pkg::T_RES_MS)) begin
          res_timeout <= 1'b1;
          state_reg <= H_IDLE;
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign link.verify_cmd_n = ~strobe_reg[rch_pkg::IDX_VERIFY];
  assign link.start_n = ~strobe_reg[rch_pkg::IDX_START];
  assign link.confirm_key_n = ~strobe_reg[rch_pkg::IDX_CONFIRM];
  assign link.abort_n = ~strobe_reg[rch_pkg::IDX_ABORT];
  assign link.advance_program_n = ~strobe_reg[rch_pkg::IDX_ADVANCE];
  assign link.result_ack_n = ~strobe_reg[rch_pkg::IDX_ACK];
  assign link.slot_select_bit_zero_n = ~strobe_reg[rch_pkg::IDX_SLOT0];
  assign link.slot_select_bit_one_n = ~strobe_reg[rch_pkg::IDX_SLOT0 + 1];
  assign link.slot_select_bit_two_n = ~strobe_reg[rch_pkg::IDX_SLOT0 + 2];
endmodule // rch_host

// [sim/rch_properties.sv]
// Pin checks on the handshake between the two ends.
// Assumes one clock; placed beside the interface in the bench.
module rch_properties #(
  parameter int unsigned TICK_CYC = rch_pkg::CLK_PER_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire rch_pkg::rch_mode_t mode,
  input wire logic host_attached,
  input wire logic busy,
  input wire logic result_ok_n,
  input wire logic result_fail_n,
  input wire logic verify_cmd_n,
  input wire logic start_n,
  input wire logic confirm_key_n,
  input wire logic abort_n,
  input wire logic advance_program_n,
  input wire logic result_ack_n,
  input wire logic slot_select_bit_zero_n,
  input wire logic slot_select_bit_one_n,
  input wire logic slot_select_bit_two_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Gap counters
  // ----
  localparam int TK = TICK_CYC;
  localparam int B50 = 50 * TK;
  localparam int B100 = 100 * TK;
  localparam int CAP = 60 * TK;
  // Saturating, so long idle spells never wrap
  int low_cnt, att_cnt, blo_cnt, sa_cnt;
  logic all_hi, op_hi, slot_hi;
  assign op_hi = verify_cmd_n & start_n & confirm_key_n;
  assign slot_hi = slot_select_bit_zero_n & slot_select_bit_one_n
    & slot_select_bit_two_n;
  assign all_hi = op_hi & slot_hi & abort_n & advance_program_n
    & result_ack_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) low_cnt <= 0;
    else if (all_hi) low_cnt <= 0;
    else if (low_cnt < CAP) low_cnt <= low_cnt + 1;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) att_cnt <= 0;
    else if (!host_attached) att_cnt <= 0;
    else if (att_cnt < CAP) att_cnt <= att_cnt + 1;
  end
  // Starts saturated: no busy fall yet means no gap owed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) blo_cnt <= CAP;
    else if (busy) blo_cnt <= 0;
    else if (blo_cnt < CAP) blo_cnt <= blo_cnt + 1;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) sa_cnt <= CAP;
    else if ($fell(slot_hi) || $fell(advance_program_n)) sa_cnt <= 0;
    else if (sa_cnt < CAP) sa_cnt <= sa_cnt + 1;
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_busy_std: assert property (
    mode == rch_pkg::MODE_STD && $fell(op_hi) |-> ##[1:B50] busy)
    else $error("busy late, standard mode");
  a_busy_slot: assert property (
    mode == rch_pkg::MODE_SLOT && $fell(op_hi) |-> ##[1:B100] busy)
    else $error("busy late, slot mode");
  a_result_after_ack: assert property (
    $fell(result_ack_n) |-> ##[1:B50] (!result_ok_n || !result_fail_n))
    else $error("result line late after ack");
  a_ack_gap: assert property (
    $fell(result_ack_n) |->
      blo_cnt >= ((mode == rch_pkg::MODE_SLOT) ? 5 * TK : TK))
    else $error("ack too soon after busy fell");
  a_strobe_width: assert property (
    $rose(all_hi) |-> low_cnt >= B50)
    else $error("strobe low too short");
  a_attach_gap: assert property (
    $fell(all_hi) |-> att_cnt >= TK)
    else $error("strobe too soon after attach");
  a_slot_gap: assert property (
    $fell(slot_hi) |-> blo_cnt >= 10 * TK)
    else $error("slot select too soon after busy");
  a_adv_gap: assert property (
    $fell(advance_program_n) |-> blo_cnt >= TK)
    else $error("advance too soon after busy");
  a_cmd_gap: assert property (
    mode != rch_pkg::MODE_STD && $fell(op_hi) |-> sa_cnt >= TK)
    else $error("command too soon after slot or advance");
  a_idle_lines: assert property (
    busy |-> result_ok_n && result_fail_n)
    else $error("result line low while busy");
endmodule // rch_properties

// [sim/remote_control_handshake_tb.sv]
// Bench: both ends joined, user sides driven, results against a model.
// Assumes the rtl package, interface and both end modules.
module remote_control_handshake_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TK = 10;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  rch_pkg::rch_mode_t mode = rch_pkg::MODE_STD;
  logic attach_req = 1'b1, op_done = 1'b0, op_pass = 1'b0;
  logic op_start, op_abort, area_advance, cmd_ready, res_valid;
  logic res_pass, res_timeout, cmd_valid = 1'b0;
  rch_pkg::rch_cmd_t op_code, cmd_code = rch_pkg::CMD_VERIFY;
  logic [2:0] slot_num, cmd_slot = 3'h0, slot_exp = 3'h0, s;
  int error_cnt = 0, n_tests = 0, seed = 32'h0000_e3f4;
  int adv_exp = 0, adv_cnt = 0, abt_cnt = 0;
  rch_pkg::rch_cmd_t code_q[$];
  bit pass_q[$];
  rch_if bus ();
  always #10 mclk = ~mclk;
  rch_device #(.TICK_CYC(TK)) i_rch_device (.mclk, .rst_n, .link(bus),
    .mode, .attach_req, .op_done, .op_pass, .op_start, .op_code,
    .op_abort, .area_advance, .slot_num);
  rch_host #(.TICK_CYC(TK)) i_rch_host (.mclk, .rst_n, .link(bus),
    .mode, .cmd_valid, .cmd_code, .cmd_slot, .cmd_ready, .res_valid,
    .res_pass, .res_timeout);
  rch_properties #(.TICK_CYC(TK)) i_rch_properties (.mclk, .rst_n, .mode,
    .host_attached(bus.host_attached), .busy(bus.busy),
    .result_ok_n(bus.result_ok_n), .result_fail_n(bus.result_fail_n),
    .verify_cmd_n(bus.verify_cmd_n), .start_n(bus.start_n),
    .confirm_key_n(bus.confirm_key_n), .abort_n(bus.abort_n),
    .advance_program_n(bus.advance_program_n),
    .result_ack_n(bus.result_ack_n),
    .slot_select_bit_zero_n(bus.slot_select_bit_zero_n),
    .slot_select_bit_one_n(bus.slot_select_bit_one_n),
    .slot_select_bit_two_n(bus.slot_select_bit_two_n));
  // ----
  // Tasks
  // ----
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_for(input bit res);
    for (int i = 0; i < 30000; i++) begin
      @(negedge mclk);
      if (res ? (res_valid | res_timeout) === 1'b1 : cmd_ready === 1'b1)
        return;
    end
    error_cnt++;
    end_sim();
  endtask
  task automatic send(input rch_pkg::rch_cmd_t c, input logic [2:0] sl);
    wait_for(1'b0);
    cmd_code = c;
    cmd_slot = sl;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask
  task automatic do_op(input rch_pkg::rch_cmd_t c);
    code_q.push_back(c);
    send(c, 3'h0);
    wait_for(1'b1);
    cmp(res_timeout, 1'b0);
    cmp(res_pass, pass_q.pop_front());
  endtask
  // ----
  // Far-side job model and monitors
  // ----
  // Job outlasts the strobe: host looks for busy only after release
  initial begin
    forever begin
      @(negedge mclk);
      if (op_start === 1'b1) begin
        cmp(op_code, code_q.pop_front());
        repeat (600 + $unsigned($random(seed)) % 30) @(negedge mclk);
        op_pass = 1'($random(seed));
        pass_q.push_back(op_pass);
        op_done = 1'b1;
        @(negedge mclk);
        op_done = 1'b0;
      end
    end
  end
  always @(posedge mclk) begin
    if (area_advance === 1'b1) adv_cnt <= adv_cnt + 1;
    if (op_abort === 1'b1) abt_cnt <= abt_cnt + 1;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    cmp({bus.host_attached, bus.busy, bus.result_ok_n,
      bus.result_fail_n}, 4'hb);
    for (int m = 0; m < 3; m++) begin
      mode = rch_pkg::rch_mode_t'(m);
      s = 3'($random(seed)) | 3'h1;
      send(rch_pkg::CMD_SLOT, s);
      if (m == 1) slot_exp = s;
      send(rch_pkg::CMD_ADVANCE, 3'h0);
      if (m == 2) adv_exp++;
      send(rch_pkg::CMD_ABORT, 3'h0);
      for (int c = 0; c < 3; c++) do_op(rch_pkg::rch_cmd_t'(c));
      cmp(slot_num, slot_exp);
    end
    cmp(4'(adv_cnt), 4'(adv_exp));
    cmp(4'(abt_cnt), 4'h0);
    mode = rch_pkg::MODE_STD;
    attach_req = 1'b0;
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    cmp(slot_num, 3'h0);
    repeat (2) @(negedge mclk);
    cmp(bus.host_attached, 1'b0);
    attach_req = 1'b1;
    for (int k = 0; k < 3; k++)
      do_op(rch_pkg::rch_cmd_t'($unsigned($random(seed)) % 3));
    end_sim();
  end
endmodule // remote_control_handshake_tb
